/* pkg/dff_reg_consts.vh */
// Constants for the parallel D register with common clear
`ifndef DFF_REG_CONSTS_VH
`define DFF_REG_CONSTS_VH
`define WIDE_BITS       6
`define NARROW_BITS     4
`define DATA_MAX_BITS   6
`define CLEAR_LEVEL     1'h0
`define BIT_RESET       1'h0
`define MODE_HEX        1'h0
`define MODE_QUAD       1'h1
`define QUAD_MASK       6'h0F
`define HEX_MASK        6'h3F
`endif

/* rtl/dff_bit.v */
// One D flip-flop with synchronous reset, enable and synchronous clear taken on an enabled edge
module dff_bit (
  input  wire MCLK,  // Shared clock
  input  wire RST,   // Synchronous reset, active high
  input  wire CE,    // Clock enable
  input  wire clr_n, // Common clear, active low
  input  wire d,     // Data input
  output reg  q      // Stored bit
);
`include "dff_reg_consts.vh"
  // Clear overrides data on an enabled edge; CE low freezes the bit unless RST is high
  always @(posedge MCLK) begin
    if (RST)
      q <= `BIT_RESET;
    else if (CE) begin
      if (clr_n == `CLEAR_LEVEL)
        q <= `BIT_RESET;
      else
        q <= d;
    end
  end
endmodule

/* rtl/dff_register.v */
// Parallel D register, six-bit true-only or four-bit true/complement
module dff_register (
  input  wire       MCLK,    // Clock, 125 MHz
  input  wire       RST,     // Synchronous reset, active high
  input  wire       CE,      // Clock enable, freezes state when low
  input  wire       MODE,    // 0: six-bit true only, 1: four-bit with complements
  input  wire       CLR_N,   // Common synchronous clear, active low, taken on an enabled edge
  input  wire [5:0] D,       // Data inputs, one per bit
  output wire [5:0] Q,       // True outputs
  output wire [3:0] Q_N      // Complement outputs, four-bit mode only
);
`include "dff_reg_consts.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Mode and strobes
  wire                      clear_hit;  // Clear seen on an enabled edge
  wire                      quad_now;   // Four-bit mode in force
  wire                      quad_next;  // Four-bit mode after this edge
  reg                       mode_reg;   // Selected configuration
  reg                       mode_next;

  // Data path
  reg  [`DATA_MAX_BITS-1:0] lane_mask;  // Bits in use for this mode
  wire [`DATA_MAX_BITS-1:0] lane_d;     // Data after masking
  wire [`DATA_MAX_BITS-1:0] q_bits;     // Storage flop outputs

  // Complement side
  reg                       qn0_reg;
  reg                       qn1_reg;
  reg                       qn2_reg;
  reg                       qn3_reg;
  reg                       qn0_next;
  reg                       qn1_next;
  reg                       qn2_next;
  reg                       qn3_next;

  ////////////////////////////////////////////////////////////////////////////
  // Clear counts only on an enabled edge, as all state freezes with CE low

  assign clear_hit = CE && (CLR_N == `CLEAR_LEVEL);

  ////////////////////////////////////////////////////////////////////////////
  // Mode is caught while clear is applied, so a switch meets an empty register
  // and no stale upper bits survive into four-bit mode

  always @* begin
    mode_next = mode_reg;
    if (clear_hit)
      mode_next = MODE;
  end

  always @(posedge MCLK) begin
    if (RST)
      mode_reg <= `MODE_HEX;
    else
      mode_reg <= mode_next;
  end

  assign quad_now  = (mode_reg == `MODE_QUAD);

  assign quad_next = (mode_next == `MODE_QUAD);

  ////////////////////////////////////////////////////////////////////////////
  // Lane mask

  always @* begin
    case (mode_reg)
      `MODE_QUAD: lane_mask = `QUAD_MASK;
      `MODE_HEX:  lane_mask = `HEX_MASK;
      default:    lane_mask = `HEX_MASK;
    endcase
  end

  assign lane_d = D & lane_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Storage flops; unused lanes load zero, so outputs come straight from
  // the flops with no gating behind them

  // Bit 0

  dff_bit u_bit0 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[0]),
    .q     (q_bits[0])
  );

  // Bit 1

  dff_bit u_bit1 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[1]),
    .q     (q_bits[1])
  );

  // Bit 2

  dff_bit u_bit2 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[2]),
    .q     (q_bits[2])
  );

  // Bit 3

  dff_bit u_bit3 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[3]),
    .q     (q_bits[3])
  );

  // Bit 4

  dff_bit u_bit4 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[4]),
    .q     (q_bits[4])
  );

  // Bit 5

  dff_bit u_bit5 (
    .MCLK  (MCLK),
    .RST   (RST),
    .CE    (CE),
    .clr_n (CLR_N),
    .d     (lane_d[5]),
    .q     (q_bits[5])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Complement flops load the inverse of the masked data in four-bit mode (zero in six-bit mode), and set on clear
  // only when MODE selects four bits on that clearing edge, whatever the current width

  // Complement of bit 0

  always @* begin
    qn0_next = qn0_reg;
    if (clear_hit)
      qn0_next = quad_next;
    else if (CE)
      qn0_next = quad_now & ~lane_d[0];
  end

  always @(posedge MCLK) begin
    if (RST)
      qn0_reg <= `BIT_RESET;
    else
      qn0_reg <= qn0_next;
  end

  // Complement of bit 1

  always @* begin
    qn1_next = qn1_reg;
    if (clear_hit)
      qn1_next = quad_next;
    else if (CE)
      qn1_next = quad_now & ~lane_d[1];
  end

  always @(posedge MCLK) begin
    if (RST)
      qn1_reg <= `BIT_RESET;
    else
      qn1_reg <= qn1_next;
  end

  // Complement of bit 2

  always @* begin
    qn2_next = qn2_reg;
    if (clear_hit)
      qn2_next = quad_next;
    else if (CE)
      qn2_next = quad_now & ~lane_d[2];
  end

  always @(posedge MCLK) begin
    if (RST)
      qn2_reg <= `BIT_RESET;
    else
      qn2_reg <= qn2_next;
  end

  // Complement of bit 3

  always @* begin
    qn3_next = qn3_reg;
    if (clear_hit)
      qn3_next = quad_next;
    else if (CE)
      qn3_next = quad_now & ~lane_d[3];
  end

  always @(posedge MCLK) begin
    if (RST)
      qn3_reg <= `BIT_RESET;
    else
      qn3_reg <= qn3_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  // Complements read zero in six-bit mode

  assign Q   = q_bits;
  assign Q_N = {qn3_reg, qn2_reg, qn1_reg, qn0_reg};

endmodule

/* bench/dff_register_properties.sv */
// Port checks
module dff_register_properties (input wire MCLK, RST, CE, MODE, CLR_N,
  input wire [5:0] D, Q, input wire [3:0] Q_N);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_clr; CE && !CLR_N |=> Q == 6'h00; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_ld; CLR_N && CE |=> Q[3:0] == $past(D[3:0]); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_hold; !CE |=> $stable(Q) && $stable(Q_N); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_clr_quad; CE && !CLR_N && MODE |=> Q_N == 4'hF; endproperty
  a_clr_quad: assert property (p_clr_quad) else $error("clr quad");
  property p_clr_hex; CE && !CLR_N && !MODE |=> Q_N == 4'h0; endproperty
  a_clr_hex: assert property (p_clr_hex) else $error("clr hex");
  property p_upper; CE && CLR_N && (Q_N != 4'h0) |=> Q[5:4] == 2'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper");
endmodule

/* bench/dff_register_partner.sv */
// Random drive
module dff_register_partner (input wire MCLK, output logic CE, MODE, CLR_N,
  output logic [5:0] D);
  timeunit 1ns; timeprecision 1ps;
  integer seed = 32'h0DE2;
  initial {CE, MODE, CLR_N, D} = 9'h000;
  always @(posedge MCLK) {CE, MODE, CLR_N, D} <= $random(seed);
endmodule

/* bench/dff_register_bench.sv */
// Model bench
module dff_register_bench;
  timeunit 1ns; timeprecision 1ps;
  `define CHK(a, b) total_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t mismatch", $time); end
  logic MCLK = 0, RST = 1, CE, MODE, CLR_N, m;
  logic [5:0] D, Q, q;
  logic [3:0] Q_N;
  integer err_total = 0, total_checks = 0, n = 0;
  always #4 MCLK = ~MCLK;
  dff_register u_dff_register (.*);
  dff_register_partner u_dff_register_partner (.*);
  task print_verdict; $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish; endtask
  always @(posedge MCLK) begin
    if (RST) {q, m} <= 7'h00;
    else if (CE) begin
      if (!CLR_N) {q, m} <= {6'h00, MODE};
      else q <= D;
    end
    if (++n > 4000) begin err_total++; print_verdict; end
  end
  always @(negedge MCLK) if (!RST) begin
    `CHK(Q, m ? {2'h0, q[3:0]} : q)
    `CHK(Q_N, m ? ~q[3:0] : 4'h0)
  end
  initial begin repeat (12) @(posedge MCLK); RST <= 0; repeat (3000) @(negedge MCLK); print_verdict; end
endmodule
bind dff_register dff_register_properties u_dff_register_properties (.*);
